// [rtl/dad_core.sv]
// Data address former and two-word decoder with dual-access data RAM.
// Assumes the instruction pipeline and USB engine run on ref_clk and that
// peripheral special registers answer sfr_rdata in the same cycle as the read strobe.
`timescale 1ns/1ps
`default_nettype none
module dad_core #(
   parameter int RAM_BYTES = dad_pkg::RAM_BYTES,
   parameter int IMPL_BANKS = dad_pkg::BANK_COUNT
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire dad_pkg::dad_pipe_req_t pipe_req,
   input wire dad_pkg::dad_pipe_wr_t pipe_wr,
   input wire logic usb_en,
   input wire dad_pkg::dad_usb_req_t usb_req,
   input wire logic [dad_pkg::DATA_W-1:0] sfr_rdata,
   output logic [3:0] phase,
   output logic [dad_pkg::DATA_W-1:0] rd_data,
   output logic [dad_pkg::ADDR_W-1:0] literal,
   output logic literal_valid,
   output logic second_nop,
   output logic pcl_wr,
   output logic [dad_pkg::DATA_W-1:0] pcl_data,
   output logic status_upd,
   output logic unimpl_access,
   output dad_pkg::dad_sfr_bus_t sfr_bus,
   output logic [dad_pkg::DATA_W-1:0] bank_pointer,
   output logic [dad_pkg::DATA_W-1:0] usb_rdata,
   output logic usb_rvalid
);
   localparam int AW = dad_pkg::ADDR_W;
   localparam int DW = dad_pkg::DATA_W;
   localparam int WW = dad_pkg::WORD_W;
   localparam logic [4:0] IMPL_BANKS_W = 5'(IMPL_BANKS);
   localparam logic [AW:0] RAM_TOP = (AW+1)'(RAM_BYTES);

   dad_pkg::dad_phase_t phase_r, phase_nxt;
   logic [WW-1:0] word_r;
   logic exec_r;
   logic file_op_r;
   logic pend_r, pend_nxt;
   logic pend_ff_r;
   logic [3:0] bp_r;
   logic [AW-1:0] op_addr_r;
   logic [DW-1:0] rd_data_r;
   logic [DW-1:0] mv_data_r;
   logic [AW-1:0] literal_r;
   logic literal_valid_r;
   logic second_nop_r;
   logic pcl_wr_r;
   logic [DW-1:0] pcl_data_r;
   logic status_upd_r;
   logic unimpl_r;
   dad_pkg::dad_sfr_bus_t sfr_bus_r;
   logic sfr_pending_r;
   logic [DW-1:0] usb_rdata_r;
   logic usb_rvalid_r;
   // Plain flops with no reset so contents survive every reset
   logic [DW-1:0] ram [RAM_BYTES];

   // Decode of the executing word
   wire is_second = word_r[15:12] == dad_pkg::SECOND_WORD_TAG;
   wire is_move_ff = word_r[15:12] == dad_pkg::MOVE_FF_TAG;
   wire is_load_bank = word_r[15:4] == dad_pkg::LOAD_BANK_PFX;
   wire is_call = word_r[15:9] == dad_pkg::CALL_PFX;
   wire is_goto = word_r[15:8] == dad_pkg::GOTO_PFX;
   wire is_load_fsr = word_r[15:8] == dad_pkg::LOAD_FSR_PFX;
   wire is_first = is_move_ff | is_call | is_goto | is_load_fsr;
   wire second_paired = exec_r & is_second & pend_r;
   wire second_alone = exec_r & is_second & ~pend_r;
   wire move_src = exec_r & is_move_ff;
   wire move_dst = second_paired & pend_ff_r;
   wire file_exec = exec_r & file_op_r & ~is_second;

   // Address forming
   wire [7:0] low8 = word_r[7:0];
   wire access_bit = word_r[dad_pkg::ACCESS_BIT_POS];
   wire [3:0] access_bank = (low8 < dad_pkg::ACCESS_SPLIT) ?
      dad_pkg::ACCESS_LO_BANK : dad_pkg::ACCESS_HI_BANK;
   wire [AW-1:0] banked_addr = {bp_r, low8};
   // No bank pointer term on the access path, so one cycle suffices
   wire [AW-1:0] access_addr = {access_bank, low8};
   wire [AW-1:0] file_addr = access_bit ? banked_addr : access_addr;
   // Full literal addresses bypass the bank pointer
   wire [AW-1:0] op_addr = (move_src | move_dst) ? word_r[11:0] : file_addr;
   wire op_valid = move_src | move_dst | file_exec;

   // Region decode over the 4096-byte space
   // Top bank always present, as the special registers live there
   wire bank_ok = (op_addr_r[11:8] == dad_pkg::ACCESS_HI_BANK) |
      ({1'b0, op_addr_r[11:8]} < IMPL_BANKS_W);
   wire in_ram = bank_ok & ({1'b0, op_addr_r} < RAM_TOP);
   wire in_sfr = bank_ok & (op_addr_r >= dad_pkg::SFR_BASE);
   wire is_bp = in_sfr & (op_addr_r == dad_pkg::BANK_PTR_ADDR);
   wire is_pcl = in_sfr & (op_addr_r == dad_pkg::PCL_ADDR);
   wire is_ext_sfr = in_sfr & ~is_bp;
   wire [DW-1:0] bp_read = {dad_pkg::BANK_PTR_PAD, bp_r};
   wire [DW-1:0] ram_read = ram[op_addr_r];
   // Holes and missing banks read as zero
   wire [DW-1:0] rd_mux = in_ram ? ram_read :
                          is_bp ? bp_read :
                          is_ext_sfr ? sfr_rdata : dad_pkg::ZERO_BYTE;

   // Destination write at Q4
   wire wr_req = (file_exec & pipe_wr.we) | move_dst;
   wire [DW-1:0] wr_byte = move_dst ? mv_data_r : pipe_wr.data;
   wire wr_phase = phase_r == dad_pkg::DAD_Q4;
   wire core_ram_we = wr_phase & wr_req & in_ram;
   wire core_bp_we = wr_phase & wr_req & is_bp;
   wire core_sfr_we = wr_phase & wr_req & is_ext_sfr & ~is_pcl;
   wire core_pcl_we = wr_phase & wr_req & is_pcl;

   // USB side only reaches the RAM while the module is enabled
   wire usb_ok = usb_en & usb_req.req & ({1'b0, usb_req.addr} < RAM_TOP);
   wire usb_ram_we = usb_ok & usb_req.we;

   // Quarter sequencer: one instruction cycle is four clocks
   always_comb begin
      unique case (phase_r)
         dad_pkg::DAD_Q1: phase_nxt = dad_pkg::DAD_Q2;
         dad_pkg::DAD_Q2: phase_nxt = dad_pkg::DAD_Q3;
         dad_pkg::DAD_Q3: phase_nxt = dad_pkg::DAD_Q4;
         dad_pkg::DAD_Q4: phase_nxt = dad_pkg::DAD_Q1;
         default: phase_nxt = dad_pkg::DAD_Q1;
      endcase
   end

   // Pairing memory: set by an executed first word, cleared by anything else
   always_comb begin
      pend_nxt = pend_r;
      if (phase_r == dad_pkg::DAD_Q4) begin
         pend_nxt = exec_r & is_first;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phase_r <= dad_pkg::DAD_Q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // Word capture at Q1; a squashed word is held but not executed
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         word_r <= '0;
         exec_r <= 1'b0;
         file_op_r <= 1'b0;
      end else if (phase_r == dad_pkg::DAD_Q1) begin
         word_r <= pipe_req.word;
         exec_r <= pipe_req.load & ~pipe_req.squash;
         file_op_r <= pipe_req.file_op;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pend_r <= 1'b0;
         pend_ff_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         if (phase_r == dad_pkg::DAD_Q4) begin
            pend_ff_r <= move_src;
         end
      end
   end

   // Operand address and special register strobe issued in Q2
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         op_addr_r <= '0;
         sfr_pending_r <= 1'b0;
      end else if (phase_r == dad_pkg::DAD_Q2) begin
         op_addr_r <= op_addr;
         sfr_pending_r <= op_valid;
      end else begin
         sfr_pending_r <= 1'b0;
      end
   end

   // Operand captured at end of Q3, once the peripheral has answered
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rd_data_r <= '0;
         mv_data_r <= '0;
         unimpl_r <= 1'b0;
      end else if (phase_r == dad_pkg::DAD_Q3) begin
         rd_data_r <= op_valid ? rd_mux : dad_pkg::ZERO_BYTE;
         unimpl_r <= op_valid & ~bank_ok;
         if (move_src) begin
            mv_data_r <= rd_mux;
         end
      end
   end

   // Bank pointer: load literal and data-space writes, low nibble only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         bp_r <= dad_pkg::BANK_PTR_RESET;
      end else if (wr_phase & exec_r & is_load_bank) begin
         bp_r <= word_r[3:0];
      end else if (core_bp_we) begin
         bp_r <= wr_byte[3:0];
      end
   end

   // Both ports land in one cycle; on the same byte the core write is last, so it wins
   always_ff @(posedge ref_clk) begin
      if (usb_ram_we) begin
         ram[usb_req.addr] <= usb_req.wdata;
      end
      if (core_ram_we) begin
         ram[op_addr_r] <= wr_byte;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         usb_rdata_r <= '0;
         usb_rvalid_r <= 1'b0;
      end else begin
         usb_rvalid_r <= usb_ok & ~usb_req.we;
         usb_rdata_r <= (usb_ok & ~usb_req.we) ? ram[usb_req.addr] : dad_pkg::ZERO_BYTE;
      end
   end

   // Special register bus: read strobe in Q2 edge, write strobe at Q4 edge
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sfr_bus_r <= '0;
      end else begin
         sfr_bus_r.re <= (phase_r == dad_pkg::DAD_Q2) & op_valid & (op_addr >= dad_pkg::SFR_BASE)
            & (op_addr != dad_pkg::BANK_PTR_ADDR);
         sfr_bus_r.we <= core_sfr_we;
         if (phase_r == dad_pkg::DAD_Q2) begin
            sfr_bus_r.addr <= op_addr;
         end
         if (core_sfr_we) begin
            sfr_bus_r.wdata <= wr_byte;
         end
      end
   end

   // Q4 pulses back to the pipeline
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pcl_wr_r <= 1'b0;
         pcl_data_r <= '0;
         status_upd_r <= 1'b0;
         literal_r <= '0;
         literal_valid_r <= 1'b0;
         second_nop_r <= 1'b0;
      end else begin
         pcl_wr_r <= core_pcl_we;
         if (core_pcl_we) begin
            pcl_data_r <= wr_byte;
         end
         // Flags follow the operation even when the target bank is missing
         status_upd_r <= wr_phase & file_exec;
         literal_valid_r <= wr_phase & second_paired;
         if (wr_phase & second_paired) begin
            literal_r <= word_r[11:0];
         end
         second_nop_r <= wr_phase & second_alone;
      end
   end

   assign phase = phase_r;
   assign rd_data = rd_data_r;
   assign literal = literal_r;
   assign literal_valid = literal_valid_r;
   assign second_nop = second_nop_r;
   assign pcl_wr = pcl_wr_r;
   assign pcl_data = pcl_data_r;
   assign status_upd = status_upd_r;
   assign unimpl_access = unimpl_r;
   assign sfr_bus = sfr_bus_r;
   assign bank_pointer = bp_read;
   assign usb_rdata = usb_rdata_r;
   assign usb_rvalid = usb_rvalid_r;
endmodule
`default_nettype wire

// [shared/dad_pkg.sv]
// Constants, encodings and carrier types for the data address and two-word decode block.
// Assumes one 50 MHz core clock and a pipeline that hands over one word per instruction cycle.
package dad_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int RAM_BYTES = 3904;
   localparam int BANK_COUNT = 16;
   localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
   localparam logic [3:0] MOVE_FF_TAG = 4'hC;
   localparam logic [11:0] LOAD_BANK_PFX = 12'h010;
   localparam logic [6:0] CALL_PFX = 7'h76;
   localparam logic [7:0] GOTO_PFX = 8'hEF;
   localparam logic [7:0] LOAD_FSR_PFX = 8'hEE;
   localparam int ACCESS_BIT_POS = 8;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [11:0] SFR_BASE = 12'hF40;
   localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;
   localparam logic [11:0] PCL_ADDR = 12'hFF9;
   localparam logic [3:0] BANK_PTR_RESET = 4'h0;
   localparam logic [3:0] BANK_PTR_PAD = 4'h0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   typedef enum logic [3:0] {
      DAD_Q1 = 4'b0001,
      DAD_Q2 = 4'b0010,
      DAD_Q3 = 4'b0100,
      DAD_Q4 = 4'b1000
   } dad_phase_t;

   typedef struct packed {
      logic load;
      logic squash;
      logic file_op;
      logic [WORD_W-1:0] word;
   } dad_pipe_req_t;

   typedef struct packed {
      logic we;
      logic [DATA_W-1:0] data;
   } dad_pipe_wr_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dad_usb_req_t;

   typedef struct packed {
      logic re;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dad_sfr_bus_t;
endpackage

// [sim/dad_chk.sv]
// Port-level checks for the data address and two-word decode core.
// Assumes binding onto dad_core; one ref_clk domain, resetn sync low.
`timescale 1ns/1ps
`default_nettype none
module dad_chk #(
   parameter int RAM_BYTES = 3904
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire dad_pkg::dad_pipe_req_t pipe_req,
   input wire dad_pkg::dad_pipe_wr_t pipe_wr,
   input wire logic usb_en,
   input wire dad_pkg::dad_usb_req_t usb_req,
   input wire logic [3:0] phase,
   input wire logic [11:0] literal,
   input wire logic literal_valid,
   input wire logic second_nop,
   input wire logic pcl_wr,
   input wire logic [7:0] pcl_data,
   input wire logic status_upd,
   input wire dad_pkg::dad_sfr_bus_t sfr_bus,
   input wire logic [7:0] bank_pointer,
   input wire logic usb_rvalid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic usb_rd = usb_en && usb_req.req && !usb_req.we && int'(usb_req.addr) < RAM_BYTES;
   wire logic exec_fop = phase == 4'b0001 && pipe_req.load && !pipe_req.squash && pipe_req.file_op;
   property p_phase;
      phase == 4'b0001 |=> phase == 4'b0010 ##1 phase == 4'b0100 ##1 phase == 4'b1000;
   endproperty
   property p_lit;
      literal_valid |-> phase == 4'b0001 && literal == $past(pipe_req.word[11:0], 4);
   endproperty
   property p_tag;
      literal_valid || second_nop |-> $past(pipe_req.word[15:12], 4) == 4'hF;
   endproperty
   property p_nop;
      second_nop |-> !literal_valid;
   endproperty
   property p_status;
      exec_fop |-> ##4 status_upd;
   endproperty
   property p_bank_hi;
      bank_pointer[7:4] == 4'h0;
   endproperty
   property p_pcl;
      pcl_wr |-> pcl_data == $past(pipe_wr.data) && $past(phase) == 4'b1000;
   endproperty
   property p_sfr;
      sfr_bus.re || sfr_bus.we |-> sfr_bus.addr >= 12'hF40 && !(sfr_bus.we && sfr_bus.addr == 12'hFF9);
   endproperty
   property p_usb;
      1'b1 |=> usb_rvalid == $past(usb_rd);
   endproperty
   a_phase: assert property (p_phase) else $error("quarter order broken");
   a_lit: assert property (p_lit) else $error("literal wrong");
   a_tag: assert property (p_tag) else $error("second word tag wrong");
   a_nop: assert property (p_nop) else $error("lone word paired");
   a_status: assert property (p_status) else $error("status pulse missing");
   a_bank_hi: assert property (p_bank_hi) else $error("bank upper bits set");
   a_pcl: assert property (p_pcl) else $error("pc low write wrong");
   a_sfr: assert property (p_sfr) else $error("special bus address wrong");
   a_usb: assert property (p_usb) else $error("usb answer wrong");
   c_lit: cover property (literal_valid);
   c_nop: cover property (second_nop);
   c_pcl: cover property (pcl_wr);
   c_usb: cover property (usb_rvalid);
   c_sfr: cover property (sfr_bus.we);
endmodule
`default_nettype wire

// [sim/dad_usb_eng.sv]
// Behavioural USB engine issuing single RAM accesses.
// Assumes the bench calls access(); drives just after falling edges.
`timescale 1ns/1ps
`default_nettype none
module dad_usb_eng (
   input wire logic ref_clk,
   output var dad_pkg::dad_usb_req_t usb_req,
   input wire logic [7:0] usb_rdata,
   input wire logic usb_rvalid
);
   initial usb_req = '0;
   // Buffer descriptors kept in bank 4
   task automatic access(input logic we, input logic [11:0] a, input logic [7:0] wd,
         output logic [7:0] rd, output logic rv);
      @(negedge ref_clk);
      usb_req = '{req: 1'b1, we: we, addr: a, wdata: wd};
      @(negedge ref_clk);
      rd = usb_rdata;
      rv = usb_rvalid;
      // Released lines change, so stale values never pass
      usb_req = '{req: 1'b0, we: 1'b0, addr: ~a, wdata: ~wd};
   endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for dad_core with a behavioural USB engine.
// Assumes dad_pkg compiled first; bank 14 left missing to reach drop logic.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk, resetn, usb_en, lv, sn, su, pw, rv;
   logic literal_valid, second_nop, pcl_wr, status_upd, unimpl_access, usb_rvalid;
   dad_pkg::dad_pipe_req_t pipe_req;
   dad_pkg::dad_pipe_wr_t pipe_wr;
   dad_pkg::dad_usb_req_t usb_req;
   dad_pkg::dad_sfr_bus_t sfr_bus;
   logic [3:0] phase;
   logic [7:0] rd_data, pcl_data, bank_pointer, usb_rdata, rd, sfr_rd;
   logic [11:0] literal;
   int n_fail = 0;
   int num_checks = 0;
   dad_core #(.IMPL_BANKS(14)) i_dad_core (.ref_clk(ref_clk), .resetn(resetn),
      .pipe_req(pipe_req), .pipe_wr(pipe_wr), .usb_en(usb_en), .usb_req(usb_req),
      .sfr_rdata(sfr_rd), .phase(phase), .rd_data(rd_data), .literal(literal),
      .literal_valid(literal_valid), .second_nop(second_nop), .pcl_wr(pcl_wr),
      .pcl_data(pcl_data), .status_upd(status_upd), .unimpl_access(unimpl_access),
      .sfr_bus(sfr_bus), .bank_pointer(bank_pointer), .usb_rdata(usb_rdata),
      .usb_rvalid(usb_rvalid));
   dad_usb_eng i_dad_usb_eng (.ref_clk(ref_clk), .usb_req(usb_req), .usb_rdata(usb_rdata),
      .usb_rvalid(usb_rvalid));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: literal %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One instruction cycle; flags are caught in the following Q1
   task automatic exec(input logic [15:0] w, input logic fo, input logic we,
         input logic [7:0] d, input logic sq);
      int i;
      i = 0;
      while (phase !== 4'b0001 && i < 8) begin
         @(negedge ref_clk);
         i++;
      end
      pipe_req = '{load: 1'b1, squash: sq, file_op: fo, word: w};
      @(negedge ref_clk);
      pipe_req.load = 1'b0;
      repeat (2) @(negedge ref_clk);
      rd = rd_data;
      pipe_wr = '{we: we, data: d};
      @(negedge ref_clk);
      {lv, sn, su, pw} = {literal_valid, second_nop, status_upd, pcl_wr};
      pipe_wr.we = 1'b0;
   endtask
   task automatic fop(input logic a, input logic [7:0] f, input logic we, input logic [7:0] d);
      exec({7'h29, a, f}, 1'b1, we, d, 1'b0);
   endtask
   task automatic bank(input logic [3:0] k);
      exec({12'h010, k}, 1'b0, 1'b0, 8'h00, 1'b0);
   endtask
   initial begin
      #100000;
      n_fail++;
      $display("ERROR %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      resetn = 1'b0;
      usb_en = 1'b0;
      pipe_req = '0;
      pipe_wr = '0;
      sfr_rd = 8'h9C;
      repeat (16) @(negedge ref_clk);
      resetn = 1'b1;
      chk8(bank_pointer, 8'h00);
      bank(4'h3);
      chk8(bank_pointer, 8'h03);
      fop(1'b1, 8'h20, 1'b1, 8'hA5);
      fop(1'b1, 8'h20, 1'b0, 8'h00);
      chk8(rd, 8'hA5);
      fop(1'b0, 8'h10, 1'b1, 8'h5A);
      chk1(su, 1'b1);
      bank(4'h0);
      fop(1'b1, 8'h10, 1'b0, 8'h00);
      chk8(rd, 8'h5A);
      bank(4'h5);
      fop(1'b0, 8'hE0, 1'b0, 8'h00);
      chk8(rd, 8'h05);
      fop(1'b0, 8'hE0, 1'b1, 8'hF7);
      chk8(bank_pointer, 8'h07);
      bank(4'hF);
      fop(1'b1, 8'hF9, 1'b1, 8'h44);
      chk1(pw, 1'b1);
      chk8(pcl_data, 8'h44);
      fop(1'b0, 8'h80, 1'b1, 8'h6B);
      chk8(rd, 8'h9C);
      chk1(sfr_bus.we, 1'b1);
      chk12(sfr_bus.addr, 12'hF80);
      chk8(sfr_bus.wdata, 8'h6B);
      exec(16'hC320, 1'b0, 1'b0, 8'h00, 1'b0);
      exec(16'hF111, 1'b0, 1'b0, 8'h00, 1'b0);
      chk1(lv, 1'b1);
      chk12(literal, 12'h111);
      bank(4'h1);
      fop(1'b1, 8'h11, 1'b0, 8'h00);
      chk8(rd, 8'hA5);
      exec(16'hC320, 1'b0, 1'b0, 8'h00, 1'b1);
      exec(16'hF456, 1'b0, 1'b0, 8'h00, 1'b0);
      chk1(sn, 1'b1);
      chk1(lv, 1'b0);
      bank(4'hE);
      fop(1'b1, 8'h05, 1'b1, 8'h77);
      chk1(su, 1'b1);
      fop(1'b1, 8'h05, 1'b0, 8'h00);
      chk8(rd, 8'h00);
      chk1(unimpl_access, 1'b1);
      usb_en = 1'b1;
      i_dad_usb_eng.access(1'b1, 12'h400, 8'h3C, rd, rv);
      i_dad_usb_eng.access(1'b0, 12'h400, 8'h00, rd, rv);
      chk1(rv, 1'b1);
      chk8(rd, 8'h3C);
      bank(4'h4);
      fop(1'b1, 8'h00, 1'b0, 8'h00);
      chk8(rd, 8'h3C);
      i_dad_usb_eng.access(1'b0, 12'hF40, 8'h00, rd, rv);
      chk1(rv, 1'b0);
      usb_en = 1'b0;
      i_dad_usb_eng.access(1'b0, 12'h400, 8'h00, rd, rv);
      chk1(rv, 1'b0);
      resetn = 1'b0;
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      bank(4'h3);
      fop(1'b1, 8'h20, 1'b0, 8'h00);
      chk8(rd, 8'hA5);
      close_out();
   end
endmodule
bind dad_core dad_chk #(.RAM_BYTES(RAM_BYTES)) i_dad_chk (.ref_clk(ref_clk), .resetn(resetn),
   .pipe_req(pipe_req), .pipe_wr(pipe_wr), .usb_en(usb_en), .usb_req(usb_req), .phase(phase),
   .literal(literal), .literal_valid(literal_valid), .second_nop(second_nop), .pcl_wr(pcl_wr),
   .pcl_data(pcl_data), .status_upd(status_upd), .sfr_bus(sfr_bus),
   .bank_pointer(bank_pointer), .usb_rvalid(usb_rvalid));
`default_nettype wire
